// File: logic/pssc_pkg.sv
// package: constants and types for the power switch state control block
package pssc_pkg;
	// clock and thresholds
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned LONG_PRESS_MS = 4000;
	localparam int unsigned LONG_PRESS_CYCLES = (CLK_HZ / 1000) * LONG_PRESS_MS;
	localparam int unsigned DEBOUNCE_US = 10_000;
	localparam int unsigned DEBOUNCE_CYCLES = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
	localparam int unsigned CNT_W = 32;
	// reset value of the global state
	localparam logic [1:0] RESET_STATE = 2'h0;

	// global states, gray along off -> working -> sleeping
	typedef enum logic [1:0] {
		PSSC_SOFT_OFF = 2'h0,
		PSSC_WORKING = 2'h1,
		PSSC_SLEEPING = 2'h3
	} pssc_state_type;

	// press classification handed from timer to controller
	typedef enum logic [1:0] {
		PSSC_PRESS_NONE = 2'h0,
		PSSC_PRESS_SHORT = 2'h1,
		PSSC_PRESS_LONG = 2'h3
	} pssc_press_type;
endpackage

// File: logic/pssc_press_if.sv
// interface: press event from the switch timer to the state controller
interface pssc_press_if;
	import pssc_pkg::*;
	logic event_valid;
	pssc_press_type kind;
	modport timer (output event_valid, output kind);
	modport ctrl (input event_valid, input kind);
endinterface

// File: logic/pssc_switch_timer.sv
// module: switch synchroniser, debounce and hold-time classifier
module pssc_switch_timer
	import pssc_pkg::*;
#(
	parameter int unsigned DEBOUNCE = DEBOUNCE_CYCLES,
	parameter int unsigned LONG_PRESS = LONG_PRESS_CYCLES
)(
	input wire logic mclk, // standby clock
	input wire logic reset_n, // sync reset, low active
	input wire logic switch_pressed_n, // raw front-panel switch, low when pressed
	pssc_press_if.timer press // classified press out
);
	import pssc_pkg::*;

	logic [2:0] sync;
	logic stable;
	logic next_stable;
	logic [CNT_W-1:0] db_cnt;
	logic [CNT_W-1:0] next_db_cnt;
	logic [CNT_W-1:0] hold_cnt;
	logic [CNT_W-1:0] next_hold_cnt;
	logic decided;
	logic next_decided;
	logic ev;
	logic next_ev;
	pssc_press_type kind;
	pssc_press_type next_kind;
	logic agree_pressed;

	// three flops; only stages two and three are compared
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			sync <= 3'h7;
		else
			sync <= {sync[1:0], switch_pressed_n};
	end
	assign agree_pressed = (sync[1] == sync[2]) ? !sync[2] : stable;

	// debounce, then hold timing; a long press fires at expiry, not on release
	always_comb
	begin
		next_stable = stable;
		next_db_cnt = db_cnt;
		next_hold_cnt = hold_cnt;
		next_decided = decided;
		next_ev = 1'b0;
		next_kind = PSSC_PRESS_NONE;
		if (agree_pressed != stable)
		begin
			next_db_cnt = db_cnt + 1'b1;
			if (db_cnt >= CNT_W'(DEBOUNCE - 1))
			begin
				next_stable = agree_pressed;
				next_db_cnt = '0;
			end
		end
		else
			next_db_cnt = '0;
		if (stable)
		begin
			if (!decided)
			begin
				next_hold_cnt = hold_cnt + 1'b1;
				if (hold_cnt >= CNT_W'(LONG_PRESS - 1))
				begin
					next_ev = 1'b1;
					next_kind = PSSC_PRESS_LONG;
					next_decided = 1'b1;
				end
				else if (!next_stable)
				begin
					next_ev = 1'b1;
					next_kind = PSSC_PRESS_SHORT;
				end
			end
			if (!next_stable)
			begin
				next_hold_cnt = '0;
				next_decided = 1'b0;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			stable <= 1'b0;
			db_cnt <= '0;
			hold_cnt <= '0;
			decided <= 1'b0;
			ev <= 1'b0;
			kind <= PSSC_PRESS_NONE;
		end
		else
		begin
			stable <= next_stable;
			db_cnt <= next_db_cnt;
			hold_cnt <= next_hold_cnt;
			decided <= next_decided;
			ev <= next_ev;
			kind <= next_kind;
		end
	end
	assign press.event_valid = ev;
	assign press.kind = kind;

	// one event per press
	a_one_event_press: assert property (@(posedge mclk) disable iff (!reset_n)
		ev |=> !ev) else $error("press event lasted two cycles");
endmodule // pssc_switch_timer

// File: logic/pssc_power_ctrl.sv
// module: power switch global state controller (top)
module pssc_power_ctrl
	import pssc_pkg::*;
#(
	parameter int unsigned DEBOUNCE = DEBOUNCE_CYCLES,
	parameter int unsigned LONG_PRESS = LONG_PRESS_CYCLES
)(
	input wire logic mclk, // standby clock, 40 MHz
	input wire logic reset_n, // sync reset from standby power, low active
	input wire logic switch_pressed_n, // front-panel power switch, low when pressed
	input wire logic power_event_wake_n, // power-management event, low active
	input wire logic pme_wake_enable, // wake on power event enabled
	input wire logic os_sleep_req, // os asks for sleeping state, pulse
	input wire logic os_off_req, // os asks for soft-off, pulse
	output pssc_pkg::pssc_state_type global_state, // current global state
	output logic main_power_on, // main supplies enabled
	output logic fan_power_on, // fan supply enabled
	output logic state_changed // one cycle on each transition
);
	import pssc_pkg::*;

	pssc_press_if press ();
	pssc_state_type state;
	pssc_state_type next_state;
	logic changed;
	logic next_changed;
	logic [2:0] pme_sync;
	logic pme_level;
	logic next_pme_level;
	logic pme_rise;
	logic [CNT_W-1:0] gap_cnt;
	logic [CNT_W-1:0] next_gap_cnt;

	pssc_switch_timer #(
		.DEBOUNCE(DEBOUNCE),
		.LONG_PRESS(LONG_PRESS)
	) u_timer (
		.mclk(mclk),
		.reset_n(reset_n),
		.switch_pressed_n(switch_pressed_n),
		.press(press.timer)
	);

	// event pin from off-board: three flops, act when stages two and three agree
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			pme_sync <= 3'h7;
		else
			pme_sync <= {pme_sync[1:0], power_event_wake_n};
	end
	always_comb
	begin
		next_pme_level = pme_level;
		if (pme_sync[1] == pme_sync[2])
			next_pme_level = !pme_sync[2];
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			pme_level <= 1'b0;
		else
			pme_level <= next_pme_level;
	end
	// edge only, so a stuck event cannot fight a later power-off
	assign pme_rise = next_pme_level && !pme_level;

	// cycles since the last press event, saturating; feeds only the spacing check
	always_comb
	begin
		next_gap_cnt = gap_cnt;
		if (press.event_valid)
			next_gap_cnt = '0;
		else if (gap_cnt != '1)
			next_gap_cnt = gap_cnt + 1'b1;
	end
	always_ff @(posedge mclk)
	begin
		if (!reset_n)
			gap_cnt <= '1;
		else
			gap_cnt <= next_gap_cnt;
	end

	// state transitions; the switch outranks os requests and wake events
	always_comb
	begin
		next_state = state;
		unique case (state)
			PSSC_SOFT_OFF:
			begin
				if (press.event_valid && press.kind == PSSC_PRESS_SHORT)
					next_state = PSSC_WORKING;
				else if (pme_rise && pme_wake_enable)
					next_state = PSSC_WORKING;
			end
			PSSC_WORKING:
			begin
				if (press.event_valid && press.kind == PSSC_PRESS_LONG)
					next_state = PSSC_SOFT_OFF;
				else if (press.event_valid && press.kind == PSSC_PRESS_SHORT)
					next_state = PSSC_SLEEPING;
				else if (os_off_req)
					next_state = PSSC_SOFT_OFF;
				else if (os_sleep_req)
					next_state = PSSC_SLEEPING;
			end
			PSSC_SLEEPING:
			begin
				if (press.event_valid && press.kind == PSSC_PRESS_LONG)
					next_state = PSSC_SOFT_OFF;
				else if (press.event_valid && press.kind == PSSC_PRESS_SHORT)
					next_state = PSSC_WORKING;
				else if (pme_rise && pme_wake_enable)
					next_state = PSSC_WORKING;
			end
			default: next_state = PSSC_SOFT_OFF;
		endcase
		next_changed = (next_state != state);
	end

	always_ff @(posedge mclk)
	begin
		if (!reset_n)
		begin
			state <= pssc_state_type'(RESET_STATE);
			changed <= 1'b0;
		end
		else
		begin
			state <= next_state;
			changed <= next_changed;
		end
	end

	assign global_state = state;
	assign main_power_on = (state == PSSC_WORKING);
	// fans share the working-only condition, off in sleep and soft-off
	assign fan_power_on = (state == PSSC_WORKING);
	assign state_changed = changed;

	// switch table: a press event, except a long press in soft-off, moves the state on the next edge
	a_off_short_on: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_SOFT_OFF && press.event_valid && press.kind == PSSC_PRESS_SHORT
		|=> state == PSSC_WORKING) else $error("short press did not power on");
	a_work_short_sleep: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_WORKING && press.event_valid && press.kind == PSSC_PRESS_SHORT
		|=> state == PSSC_SLEEPING) else $error("short press did not sleep");
	a_work_long_off: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_WORKING && press.event_valid && press.kind == PSSC_PRESS_LONG
		|=> state == PSSC_SOFT_OFF && !fan_power_on) else $error("long press no off");
	a_sleep_short_wake: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_SLEEPING && press.event_valid && press.kind == PSSC_PRESS_SHORT
		|=> state == PSSC_WORKING) else $error("short press did not wake");
	a_sleep_long_off: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_SLEEPING && press.event_valid && press.kind == PSSC_PRESS_LONG
		|=> state == PSSC_SOFT_OFF) else $error("long press in sleep no off");

	// a long press in soft-off is no power-on; only an enabled event may wake then
	a_off_long_holds: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_SOFT_OFF && press.event_valid && press.kind == PSSC_PRESS_LONG
		&& !(pme_rise && pme_wake_enable)
		|=> state == PSSC_SOFT_OFF) else $error("long press left soft-off");
	a_event_kind: assert property (@(posedge mclk) disable iff (!reset_n)
		press.event_valid |-> press.kind inside {PSSC_PRESS_SHORT, PSSC_PRESS_LONG})
		else $error("press event without a kind");

	// a second event needs the switch to settle twice, so events stay spaced
	a_event_spacing: assert property (@(posedge mclk) disable iff (!reset_n)
		press.event_valid |-> gap_cnt >= CNT_W'(DEBOUNCE))
		else $error("press events too close together");

	// wake on power event, only from sleeping or soft-off and only when enabled
	a_pme_wake: assert property (@(posedge mclk) disable iff (!reset_n)
		state != PSSC_WORKING && !press.event_valid && pme_rise && pme_wake_enable
		|=> state == PSSC_WORKING) else $error("power event did not wake");
	a_pme_masked: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_SOFT_OFF && !pme_wake_enable && !press.event_valid
		|=> state == PSSC_SOFT_OFF) else $error("wake while disabled");

	// supplies follow the state register
	a_fan_working: assert property (@(posedge mclk) disable iff (!reset_n)
		fan_power_on == (state == PSSC_WORKING)) else $error("fan in wrong state");

	// os requests act in working only, and the switch outranks them
	a_os_off: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_WORKING && !press.event_valid && os_off_req
		|=> state == PSSC_SOFT_OFF) else $error("os off request ignored");
	a_os_sleep: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_WORKING && !press.event_valid && !os_off_req && os_sleep_req
		|=> state == PSSC_SLEEPING) else $error("os sleep request ignored");

	// without a cause the state holds, whatever os requests say
	a_idle_holds: assert property (@(posedge mclk) disable iff (!reset_n)
		state != PSSC_WORKING && !press.event_valid && !(pme_rise && pme_wake_enable)
		|=> $stable(state)) else $error("state moved without a cause");
	a_work_holds: assert property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_WORKING && !press.event_valid && !os_off_req && !os_sleep_req
		|=> state == PSSC_WORKING) else $error("working left without a cause");

	// change pulse matches the state register both ways
	a_changed_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
		$changed(state) |-> state_changed) else $error("missing change pulse");
	a_change_real: assert property (@(posedge mclk) disable iff (!reset_n)
		state_changed |-> $changed(state)) else $error("change pulse without change");

	// reset lands in soft-off with supplies down and no change pulse
	a_reset_soft_off: assert property (@(posedge mclk)
		!reset_n |=> state == PSSC_SOFT_OFF && !main_power_on && !state_changed)
		else $error("reset did not reach soft-off");

	// main scenarios
	c_power_on: cover property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_SOFT_OFF ##1 state == PSSC_WORKING);
	c_sleep: cover property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_WORKING ##1 state == PSSC_SLEEPING);
	c_fail_safe: cover property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_WORKING ##1 state == PSSC_SOFT_OFF);
	c_sleep_off: cover property (@(posedge mclk) disable iff (!reset_n)
		state == PSSC_SLEEPING ##1 state == PSSC_SOFT_OFF);
	c_pme: cover property (@(posedge mclk) disable iff (!reset_n)
		pme_rise && pme_wake_enable && state == PSSC_SLEEPING);
endmodule // pssc_power_ctrl

// File: dv/pssc_switch_model.sv
// partner model: front-panel power switch and power event line
module pssc_switch_model (
	input wire logic mclk, // standby clock
	output logic switch_pressed_n, // switch contact, pulled high when open
	output logic power_event_wake_n // event line, pulled high when idle
);
	timeunit 1ns;
	timeprecision 100ps;
	// both lines sit at their pull-up level when idle
	initial
	begin
		switch_pressed_n = 1'h1;
		power_event_wake_n = 1'h1;
	end
	// contact bounce first, so a weak filter would take extra presses
	task automatic press(input int hold, input bit bounce);
		int i;
		for (i = 0; i < 3 && bounce; i++)
		begin
			@(posedge mclk) switch_pressed_n <= 1'h0;
			@(posedge mclk) switch_pressed_n <= 1'h1;
		end
		@(posedge mclk) switch_pressed_n <= 1'h0;
		repeat (hold) @(posedge mclk);
		switch_pressed_n <= 1'h1;
	endtask
	// event line pulled low for a few cycles, then released
	task automatic event_pulse();
		@(posedge mclk) power_event_wake_n <= 1'h0;
		repeat (8) @(posedge mclk);
		power_event_wake_n <= 1'h1;
	endtask
endmodule // pssc_switch_model

// File: dv/power_switch_state_control_tb.sv
// testbench: power switch state control, press table then odd cases
module power_switch_state_control_tb
	import pssc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {int hold; pssc_state_type exp;} pssc_row_type;
	logic mclk = 1'h0;
	logic reset_n = 1'h0;
	logic pme_wake_enable = 1'h1;
	logic os_sleep_req = 1'h0;
	logic os_off_req = 1'h0;
	logic switch_pressed_n;
	logic power_event_wake_n;
	pssc_state_type global_state;
	logic main_power_on;
	logic fan_power_on;
	logic state_changed;
	int num_errors = 0;
	int samples_checked = 0;
	int pulses = 0;
	pssc_row_type rows [7];
	// short counts keep the run brief; expectations use these values
	pssc_power_ctrl #(.DEBOUNCE(4), .LONG_PRESS(200)) dut (.mclk(mclk), .reset_n(reset_n),
		.switch_pressed_n(switch_pressed_n), .power_event_wake_n(power_event_wake_n),
		.pme_wake_enable(pme_wake_enable), .os_sleep_req(os_sleep_req),
		.os_off_req(os_off_req), .global_state(global_state),
		.main_power_on(main_power_on), .fan_power_on(fan_power_on),
		.state_changed(state_changed));
	pssc_switch_model sw (.mclk(mclk), .switch_pressed_n(switch_pressed_n),
		.power_event_wake_n(power_event_wake_n));
	always #12.5 mclk = ~mclk;
	// count transition pulses between checks
	always @(posedge mclk)
	begin
		if (state_changed === 1'h1)
			pulses++;
	end
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// bounded wait for the state, then let the release filter settle
	task automatic expect_state(input pssc_state_type exp, input int npulse);
		int n;
		n = 0;
		while (global_state !== exp && n < 600)
		begin
			@(posedge mclk);
			n++;
		end
		repeat (12) @(posedge mclk);
		check({2'h0, global_state}, {2'h0, exp});
		check({3'h0, fan_power_on}, {3'h0, exp == PSSC_WORKING});
		check({3'h0, main_power_on}, {3'h0, exp == PSSC_WORKING});
		check(4'(pulses), 4'(npulse));
		pulses = 0;
		$display("test done t=%0t state=%h", $time, global_state);
	endtask
	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic os_pulse(input bit off);
		@(posedge mclk);
		os_off_req <= off;
		os_sleep_req <= !off;
		@(posedge mclk);
		os_off_req <= 1'h0;
		os_sleep_req <= 1'h0;
	endtask
	// a hang counts as a mismatch
	initial
	begin
		repeat (40000) @(posedge mclk);
		num_errors++;
		close_out();
	end
	initial
	begin
		rows = '{'{40, PSSC_WORKING}, '{40, PSSC_SLEEPING}, '{40, PSSC_WORKING},
			'{300, PSSC_SOFT_OFF}, '{40, PSSC_WORKING}, '{40, PSSC_SLEEPING},
			'{300, PSSC_SOFT_OFF}};
		repeat (5) @(posedge mclk);
		reset_n <= 1'h1;
		expect_state(PSSC_SOFT_OFF, 0);
		// short presses from each state, long presses from working and sleeping only
		foreach (rows[i])
		begin
			sw.press(rows[i].hold, 1'h1);
			expect_state(rows[i].exp, 1);
		end
		sw.press(2, 1'h0);
		expect_state(PSSC_SOFT_OFF, 0);
		// os requests are ignored in soft-off
		os_pulse(1'h0);
		os_pulse(1'h1);
		expect_state(PSSC_SOFT_OFF, 0);
		pme_wake_enable <= 1'h0;
		sw.event_pulse();
		expect_state(PSSC_SOFT_OFF, 0);
		pme_wake_enable <= 1'h1;
		sw.event_pulse();
		expect_state(PSSC_WORKING, 1);
		sw.event_pulse();
		expect_state(PSSC_WORKING, 0);
		os_pulse(1'h0);
		expect_state(PSSC_SLEEPING, 1);
		sw.event_pulse();
		expect_state(PSSC_WORKING, 1);
		os_pulse(1'h1);
		expect_state(PSSC_SOFT_OFF, 1);
		sw.event_pulse();
		expect_state(PSSC_WORKING, 1);
		// reset in mid-run drops back to soft-off
		@(posedge mclk) reset_n <= 1'h0;
		repeat (5) @(posedge mclk);
		reset_n <= 1'h1;
		pulses = 0;
		expect_state(PSSC_SOFT_OFF, 0);
		sw.event_pulse();
		expect_state(PSSC_WORKING, 1);
		// long press must act while the switch is still held
		fork
			sw.press(300, 1'h0);
		join_none
		repeat (260) @(posedge mclk);
		check({switch_pressed_n, 1'h0, global_state}, {1'h0, 1'h0, PSSC_SOFT_OFF});
		expect_state(PSSC_SOFT_OFF, 1);
		// the release after a long press must make no event
		repeat (60) @(posedge mclk);
		expect_state(PSSC_SOFT_OFF, 0);
		close_out();
	end
endmodule // power_switch_state_control_tb
